//--- logic/spr_regs.vh
// Purpose: register indexes, field positions and reset values of the system pointer block
// Assumes: byte address on the bus is four times the register index
// Notes:   every register holds one nibble in bits 3:0, upper bits read zero
`ifndef SPR_REGS_VH
`define SPR_REGS_VH

`define SPR_IDX_W            8
`define SPR_IDX_PTR3         8'h74
`define SPR_IDX_PTR2         8'h75
`define SPR_IDX_PTR1         8'h76
`define SPR_IDX_PTR0         8'h77
`define SPR_IDX_WINDOW       8'h78
`define SPR_IDX_BANK         8'h79
`define SPR_IDX_INDEX_HIGH   8'h7a
`define SPR_IDX_INDEX_MIDDLE 8'h7b
`define SPR_IDX_INDEX_LOW    8'h7c
`define SPR_IDX_STATUS       8'h7f

`define SPR_NIB_W            4
`define SPR_PTR_W            16
`define SPR_INDEX_W          11
`define SPR_ROW_PTR_W        7
`define SPR_DM_ADDR_W        11
`define SPR_RF_ADDR_W        7

`define SPR_ROW_EN_BIT       3
`define SPR_INDEX_EN_BIT     0

`define SPR_PTR_RST          16'h0000
`define SPR_PTR_ONE          16'h0001
`define SPR_NIB_RST          4'h0
`define SPR_WINDOW_POR       4'h0

`endif

//--- logic/spr_system_pointer_registers.v
// Purpose: program memory pointer, window, bank, index and row pointer system registers
// Assumes: core strobes are one-cycle pulses on clk_i; resets are synchronous to clk_i
// Notes:   registers reached over classic Wishbone, one aligned word per nibble
// Notes on behaviour
// - pointer increment op adds one to the program memory pointer
// - program memory pointer is sixteen bits, up to FFFFH
// - pointer is loadable and readable through the peripheral buffer path
// - window register is four bits at system address 78H
// - window undefined at power up (here cleared to 0 on rst_i), kept over watchdog, CE resets, clock stop
// - control file read op copies addressed nibble into the window
// - control file write op copies window into addressed location
// - bank selector is four bits at address 79H
// - bank value selects data bank directly in binary
// - bank selector writable regardless of selected bank
// - bank clears on all three resets, holds through clock stop
// - index is eleven bits from 7AH low three, 7BH, 7CH
// - index enable is bit zero of the status nibble at 7FH
// - row pointer is seven bits from 7AH low three and 7BH
// - row pointer enable is bit three of 7AH
// - index upper seven bits and row pointer share storage
// - with index enable, data access address is ORed with index
// - with row enable, indirect destination bank and row come from row pointer
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.vh"

module spr_system_pointer_registers #(
  parameter ADR_W = 10
) (
  input  wire                        clk_i,
  input  wire                        rst_i,
  input  wire                        watchdog_stack_reset_i,
  input  wire                        ce_reset_i,
  input  wire                        clock_stop_i,
  // classic wishbone slave
  input  wire                        cyc_i,
  input  wire                        stb_i,
  input  wire                        we_i,
  input  wire [ADR_W-1:0]            adr_i,
  input  wire [3:0]                  sel_i,
  input  wire [31:0]                 dat_i,
  output reg  [31:0]                 dat_o,
  output reg                         ack_o,
  // core instruction strobes
  input  wire                        pointer_increment_op_i,
  input  wire                        control_file_read_op_i,
  input  wire                        control_file_write_op_i,
  input  wire [`SPR_RF_ADDR_W-1:0]   rf_addr_i,
  input  wire [`SPR_NIB_W-1:0]       rf_rdata_i,
  output reg                         rf_write_o,
  output reg  [`SPR_RF_ADDR_W-1:0]   rf_addr_o,
  output reg  [`SPR_NIB_W-1:0]       rf_wdata_o,
  // peripheral buffer path to the pointer
  input  wire                        peripheral_buffer_load_i,
  input  wire [`SPR_PTR_W-1:0]       peripheral_buffer_data_i,
  output reg  [`SPR_PTR_W-1:0]       program_memory_pointer_o,
  // data memory address modification
  input  wire                        dm_access_i,
  input  wire [`SPR_DM_ADDR_W-1:0]   dm_addr_i,
  input  wire                        indirect_access_i,
  input  wire [`SPR_DM_ADDR_W-1:0]   indirect_addr_i,
  output reg                         dm_eff_valid_o,
  output reg  [`SPR_DM_ADDR_W-1:0]   dm_eff_addr_o,
  output reg  [`SPR_NIB_W-1:0]       data_bank_o,
  output reg                         index_enable_flag_o,
  output reg                         row_pointer_enable_flag_o
);

  // nibble storage
  reg  [`SPR_NIB_W-1:0]     nibble_transfer_window;
  reg  [`SPR_NIB_W-1:0]     data_bank_select;
  reg  [`SPR_NIB_W-1:0]     index_high_row_high;
  reg  [`SPR_NIB_W-1:0]     index_middle_row_low;
  reg  [`SPR_NIB_W-1:0]     index_low_nibble;
  reg  [`SPR_NIB_W-1:0]     status_flags_nibble;

  wire [`SPR_INDEX_W-1:0]   index_modifier;
  wire [`SPR_ROW_PTR_W-1:0] row_address_pointer;
  wire                      index_enable_flag;
  wire                      row_pointer_enable_flag;
  wire                      bus_req;
  wire                      bus_wr;
  wire [`SPR_IDX_W-1:0]     bus_idx;
  wire [`SPR_NIB_W-1:0]     bus_nib;
  wire                      soft_reset;
  wire                      core_go;
  reg  [31:0]               next_dat;

  // shared storage gives both views
  assign index_modifier          = {index_high_row_high[2:0], index_middle_row_low,
                                    index_low_nibble};
  assign row_address_pointer     = {index_high_row_high[2:0],
                                    index_middle_row_low};
  assign row_pointer_enable_flag = index_high_row_high[`SPR_ROW_EN_BIT];
  assign index_enable_flag       = status_flags_nibble[`SPR_INDEX_EN_BIT];

  assign bus_req    = cyc_i & stb_i & ~ack_o;
  assign bus_wr     = bus_req & we_i & sel_i[0];
  assign bus_idx    = adr_i[`SPR_IDX_W+1:2];
  assign bus_nib    = dat_i[`SPR_NIB_W-1:0];
  assign soft_reset = watchdog_stack_reset_i | ce_reset_i;
  assign core_go    = ~clock_stop_i;

  // wishbone answer one cycle after the request, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req) begin
        dat_o <= next_dat;
      end
    end
  end

  always @* begin
    next_dat = 32'h0000_0000;
    case (bus_idx)
      `SPR_IDX_PTR3:         next_dat[3:0] = program_memory_pointer_o[15:12];
      `SPR_IDX_PTR2:         next_dat[3:0] = program_memory_pointer_o[11:8];
      `SPR_IDX_PTR1:         next_dat[3:0] = program_memory_pointer_o[7:4];
      `SPR_IDX_PTR0:         next_dat[3:0] = program_memory_pointer_o[3:0];
      `SPR_IDX_WINDOW:       next_dat[3:0] = nibble_transfer_window;
      `SPR_IDX_BANK:         next_dat[3:0] = data_bank_select;
      `SPR_IDX_INDEX_HIGH:   next_dat[3:0] = index_high_row_high;
      `SPR_IDX_INDEX_MIDDLE: next_dat[3:0] = index_middle_row_low;
      `SPR_IDX_INDEX_LOW:    next_dat[3:0] = index_low_nibble;
      `SPR_IDX_STATUS:       next_dat[3:0] = status_flags_nibble;
      default:               next_dat      = 32'h0000_0000;
    endcase
  end

  // program memory pointer: bus write wins over buffer load over increment
  always @(posedge clk_i) begin
    if (rst_i | soft_reset) begin
      program_memory_pointer_o <= `SPR_PTR_RST;
    end else if (bus_wr && bus_idx == `SPR_IDX_PTR3) begin
      program_memory_pointer_o[15:12] <= bus_nib;
    end else if (bus_wr && bus_idx == `SPR_IDX_PTR2) begin
      program_memory_pointer_o[11:8] <= bus_nib;
    end else if (bus_wr && bus_idx == `SPR_IDX_PTR1) begin
      program_memory_pointer_o[7:4] <= bus_nib;
    end else if (bus_wr && bus_idx == `SPR_IDX_PTR0) begin
      program_memory_pointer_o[3:0] <= bus_nib;
    end else if (core_go && peripheral_buffer_load_i) begin
      program_memory_pointer_o <= peripheral_buffer_data_i;
    end else if (core_go && pointer_increment_op_i) begin
      // sixteen bit sum drops the carry
      program_memory_pointer_o <= program_memory_pointer_o + `SPR_PTR_ONE;
    end
  end

  // window: cleared only at power on, kept over the other resets
  always @(posedge clk_i) begin
    if (rst_i) begin
      nibble_transfer_window <= `SPR_WINDOW_POR;
    end else if (bus_wr && bus_idx == `SPR_IDX_WINDOW) begin
      nibble_transfer_window <= bus_nib;
    end else if (core_go && control_file_read_op_i) begin
      nibble_transfer_window <= rf_rdata_i;
    end
  end

  // control file write strobe, one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      rf_write_o <= 1'b0;
      rf_addr_o  <= {`SPR_RF_ADDR_W{1'b0}};
      rf_wdata_o <= `SPR_NIB_RST;
    end else begin
      rf_write_o <= core_go & control_file_write_op_i;
      if (core_go && (control_file_write_op_i || control_file_read_op_i)) begin
        rf_addr_o <= rf_addr_i;
      end
      if (core_go && control_file_write_op_i) begin
        rf_wdata_o <= nibble_transfer_window;
      end
    end
  end

  // bank, index and status nibbles clear on every reset
  always @(posedge clk_i) begin
    if (rst_i | soft_reset) begin
      data_bank_select     <= `SPR_NIB_RST;
      index_high_row_high  <= `SPR_NIB_RST;
      index_middle_row_low <= `SPR_NIB_RST;
      index_low_nibble     <= `SPR_NIB_RST;
      status_flags_nibble  <= `SPR_NIB_RST;
    end else if (bus_wr) begin
      case (bus_idx)
        `SPR_IDX_BANK:         data_bank_select     <= bus_nib;
        `SPR_IDX_INDEX_HIGH:   index_high_row_high  <= bus_nib;
        `SPR_IDX_INDEX_MIDDLE: index_middle_row_low <= bus_nib;
        `SPR_IDX_INDEX_LOW:    index_low_nibble     <= bus_nib;
        `SPR_IDX_STATUS:       status_flags_nibble  <= bus_nib;
        default:               data_bank_select     <= data_bank_select;
      endcase
    end
  end

  // flag and bank views, effective data memory address
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_bank_o               <= `SPR_NIB_RST;
      index_enable_flag_o       <= 1'b0;
      row_pointer_enable_flag_o <= 1'b0;
      dm_eff_valid_o            <= 1'b0;
      dm_eff_addr_o             <= {`SPR_DM_ADDR_W{1'b0}};
    end else begin
      data_bank_o               <= data_bank_select;
      index_enable_flag_o       <= index_enable_flag;
      row_pointer_enable_flag_o <= row_pointer_enable_flag;
      dm_eff_valid_o            <= core_go & (dm_access_i | indirect_access_i);
      if (core_go && indirect_access_i) begin
        if (row_pointer_enable_flag) begin
          dm_eff_addr_o <= {row_address_pointer, indirect_addr_i[3:0]};
        end else begin
          dm_eff_addr_o <= indirect_addr_i;
        end
      end else if (core_go && dm_access_i) begin
        if (index_enable_flag) begin
          dm_eff_addr_o <= dm_addr_i | index_modifier;
        end else begin
          dm_eff_addr_o <= dm_addr_i;
        end
      end
    end
  end

endmodule // spr_system_pointer_registers

`default_nettype wire

//--- dv/spr_props.sv
// Purpose: port assertions for the system pointer block
// Assumes: bound to spr_system_pointer_registers, one-cycle ack
// Notes:   bank copy lags its register by one cycle
`timescale 1ns/1ps
`default_nettype none
module spr_props #(
  parameter ADR_W = 10
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             watchdog_stack_reset_i,
  input wire logic             ce_reset_i,
  input wire logic             clock_stop_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0]       sel_i,
  input wire logic [31:0]      dat_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic             pointer_increment_op_i,
  input wire logic             control_file_write_op_i,
  input wire logic [6:0]       rf_addr_i,
  input wire logic             rf_write_o,
  input wire logic [6:0]       rf_addr_o,
  input wire logic             peripheral_buffer_load_i,
  input wire logic [15:0]      peripheral_buffer_data_i,
  input wire logic [15:0]      program_memory_pointer_o,
  input wire logic [3:0]       data_bank_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus write taken, soft reset
  wire bw = cyc_i && stb_i && we_i && !ack_o;
  wire rs = watchdog_stack_reset_i || ce_reset_i;
  a_ack_pulse:
  assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack not one pulse");
  a_nibble_wide:
  assert property (ack_o |-> dat_o[31:4] == 28'h0) else $error("read data upper bits set");
  a_ptr_incr:
  assert property (pointer_increment_op_i && !peripheral_buffer_load_i && !clock_stop_i && !bw
    && !rs |=> program_memory_pointer_o == $past(program_memory_pointer_o) + 16'h0001)
    else $error("pointer did not step by one");
  a_ptr_load:
  assert property (peripheral_buffer_load_i && !clock_stop_i && !bw && !rs
    |=> program_memory_pointer_o == $past(peripheral_buffer_data_i)) else $error("buffer load lost");
  a_stop_hold:
  assert property (clock_stop_i && !bw && !rs |=> $stable(program_memory_pointer_o))
    else $error("pointer moved during clock stop");
  a_rf_write:
  assert property (control_file_write_op_i && !clock_stop_i
    |=> rf_write_o && rf_addr_o == $past(rf_addr_i)) else $error("control file write missing");
  a_bank_write:
  assert property (bw && sel_i[0] && adr_i[ADR_W-1:2] == 8'h79 && !rs
    |=> ##1 (data_bank_o == $past(dat_i[3:0], 2) || $past(rs))) else $error("bank write lost");
  a_bank_clear:
  assert property (rs |=> ##1 (data_bank_o == 4'h0 || $past(bw))) else $error("bank not cleared");
endmodule // spr_props
`default_nettype wire

//--- dv/tb.sv
// Purpose: random and corner stimulus for the system pointer block
// Assumes: one-cycle ack, core strobes taken on the rising edge
// Notes:   expectations come from inline values and the local function f_eff
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 0, rst_i = 1, wd_rst = 0, ce_rst = 0, stop = 0, cyc = 0, stb = 0, we = 0;
  logic [9:0] adr = 0;
  logic [31:0] wdat = 0, q;
  logic [5:0] op = 0;
  logic [6:0] rfa = 0;
  logic [3:0] rfd = 0, h, m, l;
  logic [15:0] pbd = 0, p;
  logic [10:0] dma = 0, ina = 0;
  wire [31:0] dat_o;
  wire ack_o, rf_write_o, eff_v, ixe_o, mpe_o;
  wire [6:0] rf_addr_o;
  wire [3:0] rf_wdata_o, bank_o;
  wire [15:0] pmp_o;
  wire [10:0] eff_o;
  integer n_mismatch = 0, n_tests = 0, i;
  spr_system_pointer_registers dut (.clk_i(clk_i), .rst_i(rst_i), .watchdog_stack_reset_i(wd_rst),
    .ce_reset_i(ce_rst), .clock_stop_i(stop), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .pointer_increment_op_i(op[0]),
    .control_file_read_op_i(op[1]), .control_file_write_op_i(op[2]), .rf_addr_i(rfa),
    .rf_rdata_i(rfd), .rf_write_o(rf_write_o), .rf_addr_o(rf_addr_o), .rf_wdata_o(rf_wdata_o),
    .peripheral_buffer_load_i(op[3]), .peripheral_buffer_data_i(pbd),
    .program_memory_pointer_o(pmp_o), .dm_access_i(op[4]), .dm_addr_i(dma),
    .indirect_access_i(op[5]), .indirect_addr_i(ina), .dm_eff_valid_o(eff_v),
    .dm_eff_addr_o(eff_o), .data_bank_o(bank_o), .index_enable_flag_o(ixe_o),
    .row_pointer_enable_flag_o(mpe_o));
  initial forever #25 clk_i = ~clk_i;
  function automatic logic [10:0] f_eff(input logic ind, input logic e, input logic [10:0] a);
    if (ind) f_eff = h[3] ? {h[2:0], m, a[3:0]} : a;
    else f_eff = e ? (a | {h[2:0], m, l}) : a;
  endfunction
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic [7:0] idx, input logic w, input logic [3:0] d);
    integer k;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; wdat <= {28'h0, d};
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 20);
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    if (ack_o !== 1'b1) begin n_mismatch++; tally_and_finish; end
  endtask
  task fire(input logic [5:0] s, input integer n);
    @(posedge clk_i);
    op <= s;
    repeat (n) @(posedge clk_i);
    op <= 6'h0;
    @(negedge clk_i);
  endtask
  initial begin
    void'($urandom(92));
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 12; i++) begin
      wb(i < 9 ? 8'(8'h74 + i) : (i < 11 ? 8'h7f : 8'h40), 0, 0); chk(q, 0);
    end
    for (i = 0; i < 4; i++) wb(8'(8'h74 + i), 1, 4'hf);
    chk(pmp_o, 16'hffff);
    fire(6'h01, 1); chk(pmp_o, 16'h0000);
    p = 16'($urandom) & 16'h3fff; pbd <= p;
    fire(6'h08, 1); chk(pmp_o, p);
    i = $urandom % 6 + 2; fire(6'h01, i); chk(pmp_o, p + 16'(i));
    stop <= 1; fire(6'h01, 3); stop <= 0; chk(pmp_o, p + 16'(i));
    p = pmp_o;
    for (i = 0; i < 4; i++) begin wb(8'(8'h74 + i), 0, 0); chk(q, (p >> (12 - 4 * i)) & 15); end
    rfd <= 4'($urandom); fire(6'h02, 1); wb(8'h78, 0, 0); chk(q, rfd);
    rfa <= 7'($urandom); fire(6'h04, 1); chk({rf_write_o, rf_addr_o, rf_wdata_o}, {1'b1, rfa, rfd});
    for (i = 15; i >= 0; i--) begin
      wb(8'h79, 1, 4'(i)); repeat (2) @(negedge clk_i); chk(bank_o, i);
    end
    for (i = 0; i < 8; i++) begin
      h = 4'($urandom); m = 4'($urandom); l = 4'($urandom); dma <= 11'($urandom); ina <= 11'($urandom);
      wb(8'h7a, 1, h); wb(8'h7b, 1, m); wb(8'h7c, 1, l); wb(8'h7f, 1, {3'b0, i[0]});
      fire(i[1] ? 6'h20 : 6'h10, 1);
      chk({eff_v, eff_o}, {1'b1, f_eff(i[1], i[0], i[1] ? ina : dma)});
      chk({ixe_o, mpe_o}, {i[0], h[3]});
      wb(8'h7a, 0, 0); chk(q, h);
    end
    for (i = 0; i < 2; i++) begin
      wb(8'h79, 1, 4'h5); wb(8'h78, 1, 4'(i + 9));
      @(posedge clk_i);
      if (i == 0) wd_rst <= 1; else ce_rst <= 1;
      @(posedge clk_i);
      wd_rst <= 0; ce_rst <= 0;
      repeat (2) @(negedge clk_i); chk({bank_o, pmp_o}, 0);
      wb(8'h78, 0, 0); chk(q, i + 9);
      wb(8'h7b, 0, 0); chk(q, 0);
    end
    tally_and_finish;
  end
endmodule // tb
bind spr_system_pointer_registers spr_props #(.ADR_W(ADR_W)) u_props (.clk_i(clk_i),
  .rst_i(rst_i), .watchdog_stack_reset_i(watchdog_stack_reset_i), .ce_reset_i(ce_reset_i),
  .clock_stop_i(clock_stop_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .pointer_increment_op_i(pointer_increment_op_i), .control_file_write_op_i(control_file_write_op_i),
  .rf_addr_i(rf_addr_i), .rf_write_o(rf_write_o), .rf_addr_o(rf_addr_o),
  .peripheral_buffer_load_i(peripheral_buffer_load_i),
  .peripheral_buffer_data_i(peripheral_buffer_data_i),
  .program_memory_pointer_o(program_memory_pointer_o), .data_bank_o(data_bank_o));
`default_nettype wire
